// >>> hdl/ccc_pkg.sv
// Purpose: shared constants, register layout and types of the charge-cycle control block
// Assumes: 100 MHz core clock, 1 ms internal timebase
// Notes:   timer figures are counted in 1 ms timebase ticks
package ccc_pkg;
    // clock and timebase
    localparam int CLK_PERIOD_NS    = 10;
    localparam int TICK_PERIOD_NS   = 1_000_000;
    localparam int TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int INT_PULSE_NS     = 256_000;
    localparam int INT_PULSE_CYCLES = INT_PULSE_NS / CLK_PERIOD_NS;
    localparam logic [9:0] BLINK_TICKS = 10'h1f4;  // 500 ms half period, 1 Hz blink
    // safety and usb timer lengths in ms
    localparam logic [26:0] T_1H_MS  = 27'h036ee80;
    localparam logic [26:0] T_5H_MS  = 27'h112a880;
    localparam logic [26:0] T_8H_MS  = 27'h1b77400;
    localparam logic [26:0] T_12H_MS = 27'h2932e00;
    localparam logic [26:0] T_20H_MS = 27'h44aa200;
    localparam logic [26:0] T_45M_MS = 27'h02932e0;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FAST = 8'h04;
    localparam logic [7:0] REG_PRE  = 8'h08;
    localparam logic [7:0] REG_TERM = 8'h0c;
    localparam logic [7:0] REG_COMP = 8'h10;
    localparam logic [7:0] REG_MISC = 8'h14;
    localparam logic [7:0] REG_STAT = 8'h18;
    localparam logic [7:0] REG_VREG = 8'h1c;
    // reset values and writable masks
    localparam logic [7:0]  CTRL_RST = 8'h10;
    localparam logic [7:0]  FAST_RST = 8'h60;
    localparam logic [7:0]  PRE_RST  = 8'h10;
    localparam logic [7:0]  TERM_RST = 8'h8a;
    localparam logic [7:0]  COMP_RST = 8'h00;
    localparam logic [7:0]  MISC_RST = 8'h40;
    localparam logic [12:0] VREG_RST = 13'h1070;
    localparam logic [7:0]  CTRL_MSK = 8'h33;
    localparam logic [7:0]  FAST_MSK = 8'hfd;
    localparam logic [7:0]  PRE_MSK  = 8'hf0;
    localparam logic [7:0]  TERM_MSK = 8'hcf;
    localparam logic [7:0]  COMP_MSK = 8'hfc;
    localparam logic [7:0]  MISC_MSK = 8'h50;
    // field positions
    localparam int CTRL_HIZ   = 0;
    localparam int CTRL_HOST  = 1;
    localparam int CTRL_SWRST = 7;
    localparam int FAST_RED   = 0;
    localparam int TERM_COOL  = 0;
    localparam int TERM_TMREN = 3;
    localparam int TERM_EARLY = 6;
    localparam int TERM_EN    = 7;
    localparam int MISC_WARM  = 4;
    localparam int MISC_SLOW  = 6;
    // currents, voltages and resistances in mA, mV and mOhm
    localparam logic [12:0] I_SHORT_MA    = 13'h0064;
    localparam logic [12:0] PRE_BASE_MA   = 13'h0080;
    localparam logic [12:0] PRE_STEP_MA   = 13'h0080;
    localparam logic [12:0] FAST_BASE_MA  = 13'h0200;
    localparam logic [12:0] FAST_STEP_MA  = 13'h0040;
    localparam logic [12:0] V_WARM_HI_MV  = 13'h1068;
    localparam logic [12:0] V_WARM_LO_MV  = 13'h0fd2;
    localparam logic [19:0] R_STEP_MOHM   = 20'h0000a;
    localparam logic [19:0] CLAMP_STEP_MV = 20'h00010;
    localparam logic [19:0] MOHM_PER_OHM  = 20'h003e8;
    // phase and fault codes
    localparam logic [1:0] PH_OFF  = 2'b00;
    localparam logic [1:0] PH_PRE  = 2'b01;
    localparam logic [1:0] PH_FAST = 2'b10;
    localparam logic [1:0] PH_DONE = 2'b11;
    localparam logic [1:0] CFG_CHG = 2'b01;
    localparam logic [1:0] FLT_CHG = 2'b11;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_PRE   = 6'b000010,
        ST_FAST  = 6'b000100,
        ST_SUSP  = 6'b001000,
        ST_DONE  = 6'b010000,
        ST_FAULT = 6'b100000
    } ccc_state_t;

    typedef struct packed {
        logic vbat_below_2v;
        logic vbat_below_3v;
        logic vbat_below_low;
        logic vbat_above_rechg;
        logic ichg_below_term;
        logic ichg_below_800;
        logic ts_in_window;
        logic ts_cool;
        logic ts_warm;
        logic input_power_limit_loop;
        logic thermal_loop;
        logic usb100_source;
    } ccc_sense_t;

    typedef struct packed {
        logic [12:0] ichg_ma;
        logic [12:0] vreg_mv;
    } ccc_drive_t;
endpackage

// >>> hdl/ccc_top.sv
// Purpose: charge phase sequencing, termination and safety timer with an apb register file
// Assumes: comparator and loop flags are synchronous to core_clk_i
// Notes:   apb answers in the second access cycle; timers run off a 1 ms prescaler
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - phases run precondition, constant current, constant voltage
// - current and phase code chosen by battery voltage
// - precharge 256 mA, fast 2048 mA after reset
// - regulation loops suspend termination, halve timer rate
// - target raised by lesser of IR drop, clamp
// - start only inside thermistor window, leaving it suspends
// - warm zone regulates 4.2 V or 4.05 V
// - cool zone may cut current to 20%
// - terminate when full, battery switch off
// - termination sets fault field 11, interrupts host
// - no automatic termination while termination disabled
// - early done releases status pin below 800 mA
// - default mode 5 h timer, expiry sets input off
// - host mode uses duration field, expiry clears input off
// - low battery limits safety timer to 1 h
// - timer expiry sets fault field 11, interrupts
// - timer stopped while timer enable cleared
// - listed events restart the safety timer
// - slowdown disable keeps full timer rate
// - default mode usb 100 mA caps at 45 min
// - interrupt is one 256 us low pulse
// - phase field codes off, pre, fast, done
module ccc_top #(
    parameter int TICK_CYC = ccc_pkg::TICK_CYCLES,
    parameter int INT_CYC  = ccc_pkg::INT_PULSE_CYCLES
) (
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                resetn_i,
    // apb slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [7:0]          paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // sensing and pins
    input  wire ccc_pkg::ccc_sense_t sense_i,
    input  wire logic                ce_n_i,
    input  wire logic                supplement_req_i,
    // charge control
    output ccc_pkg::ccc_drive_t      drive_o,
    output logic      [1:0]          phase_o,
    output logic                     bat_switch_o,
    output logic                     stat_oe_o,
    output logic                     int_n_o,
    output logic                     hiz_o
);
    import ccc_pkg::*;

    ccc_state_t  state_reg;
    ccc_state_t  state_next;
    logic [7:0]  ctrl_reg;
    logic [7:0]  fast_reg;
    logic [7:0]  pre_reg;
    logic [7:0]  term_reg;
    logic [7:0]  comp_reg;
    logic [7:0]  misc_reg;
    logic [12:0] vreg_reg;
    logic [1:0]  fault_reg;
    logic [26:0] timer_reg;
    logic [26:0] usb_reg;
    logic [31:0] tick_reg;
    logic [31:0] int_reg;
    logic [9:0]  blink_cnt;
    logic        blink_reg;
    logic        half_reg;
    logic        ce_prev;
    logic        start_cycle;
    logic        int_ev;
    logic [12:0] ichg_next;
    logic [12:0] vreg_next;
    logic [19:0] ir_mv;
    logic [19:0] clamp_mv;

    // timer length for the present battery level and mode
    function automatic logic [26:0] timer_limit(input logic low, input logic host, input logic [1:0] dur);
        if (low)
            return T_1H_MS;
        if (!host)
            return T_5H_MS;
        case (dur)
            2'b00:   return T_5H_MS;
            2'b01:   return T_8H_MS;
            2'b10:   return T_12H_MS;
            default: return T_20H_MS;
        endcase
    endfunction

    // fast-charge current in mA from its field
    function automatic logic [12:0] fast_ma(input logic [5:0] code);
        return FAST_BASE_MA + 13'(code) * FAST_STEP_MA;
    endfunction

    // apb strobes: a transfer completes when pready is seen high
    wire acc       = psel_i & penable_i & pready_o;
    wire wr        = acc & pwrite_i;
    wire rd        = acc & ~pwrite_i;
    wire sw_rst    = wr && paddr_i == REG_CTRL && pwdata_i[CTRL_SWRST];
    wire input_off_state       = ctrl_reg[CTRL_HIZ];
    wire host_mode = ctrl_reg[CTRL_HOST];
    wire tmr_en    = term_reg[TERM_TMREN];
    wire regulate  = sense_i.input_power_limit_loop | sense_i.thermal_loop;
    wire charging  = state_reg == ST_PRE || state_reg == ST_FAST;
    wire charge_ok = ctrl_reg[5:4] == CFG_CHG && !ce_n_i && !input_off_state;
    wire tick      = tick_reg == 32'(TICK_CYC - 1);
    wire mapped    = paddr_i[1:0] == 2'b00 && paddr_i <= REG_VREG;

    // restart events of the safety timer
    wire ce_rise   = ce_n_i & ~ce_prev;
    wire cfg_on    = wr && paddr_i == REG_CTRL && ctrl_reg[5:4] == 2'b00 && pwdata_i[5:4] == CFG_CHG;
    wire ten_on    = wr && paddr_i == REG_TERM && !tmr_en && pwdata_i[TERM_TMREN];
    wire ext_rst   = ce_rise | cfg_on | ten_on | sw_rst;
    wire hiz_clr   = wr && paddr_i == REG_CTRL && input_off_state && !pwdata_i[CTRL_HIZ];

    // timer expiry and termination conditions
    wire tmr_exp   = charging && tmr_en
                     && timer_reg >= timer_limit(sense_i.vbat_below_low, host_mode, term_reg[2:1]);
    wire usb_exp   = charging && !host_mode && sense_i.usb100_source && usb_reg >= T_45M_MS;
    wire terminate = state_reg == ST_FAST && term_reg[TERM_EN] && !regulate
                     && sense_i.vbat_above_rechg && sense_i.ichg_below_term;
    wire slow      = regulate && misc_reg[MISC_SLOW];
    wire advance   = tick && charging && tmr_en && (!slow || half_reg);

    // charge phase sequencing
    always_comb begin
        state_next  = state_reg;
        start_cycle = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (charge_ok && sense_i.ts_in_window) begin
                    start_cycle = 1'b1;
                    state_next  = sense_i.vbat_below_3v ? ST_PRE : ST_FAST;
                end
            end
            ST_PRE, ST_FAST: begin
                if (!charge_ok)
                    state_next = ST_IDLE;
                else if (tmr_exp || usb_exp)
                    state_next = ST_FAULT;
                else if (!sense_i.ts_in_window)
                    state_next = ST_SUSP;
                else if (terminate)
                    state_next = ST_DONE;
                else if (state_reg == ST_PRE && !sense_i.vbat_below_3v)
                    state_next = ST_FAST;
            end
            ST_SUSP: begin
                if (!charge_ok)
                    state_next = ST_IDLE;
                else if (sense_i.ts_in_window)
                    state_next = sense_i.vbat_below_3v ? ST_PRE : ST_FAST;
            end
            ST_DONE: begin
                if (!charge_ok)
                    state_next = ST_IDLE;
                else if (!sense_i.vbat_above_rechg && sense_i.ts_in_window) begin
                    start_cycle = 1'b1;                        // recharge is a new cycle
                    state_next  = sense_i.vbat_below_3v ? ST_PRE : ST_FAST;
                end
            end
            ST_FAULT: begin
                if (ext_rst || hiz_clr)
                    state_next = ST_IDLE;
            end
        endcase
        int_ev = (state_next == ST_DONE && state_reg != ST_DONE)
                 || (state_next == ST_FAULT && state_reg != ST_FAULT);
    end

    // state register, software reset returns to idle
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || sw_rst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // prescaler and timebase derived half-rate and blink flags
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            tick_reg  <= 32'h0;
            half_reg  <= 1'b0;
            blink_cnt <= 10'h0;
            blink_reg <= 1'b0;
            ce_prev   <= 1'b1;
        end else begin
            tick_reg <= tick ? 32'h0 : tick_reg + 32'h1;
            ce_prev  <= ce_n_i;
            if (tick && charging && slow)
                half_reg <= ~half_reg;
            if (tick) begin
                blink_cnt <= (blink_cnt == BLINK_TICKS - 10'h1) ? 10'h0 : blink_cnt + 10'h1;
                if (blink_cnt == BLINK_TICKS - 10'h1)
                    blink_reg <= ~blink_reg;
            end
        end
    end

    // safety timer and usb total-time timer
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            timer_reg <= 27'h0;
            usb_reg   <= 27'h0;
        end else begin
            if (start_cycle || ext_rst)
                timer_reg <= 27'h0;
            else if (advance)
                timer_reg <= timer_reg + 27'h1;
            if (start_cycle || sw_rst)
                usb_reg <= 27'h0;
            else if (tick && charging && usb_reg != T_45M_MS)
                usb_reg <= usb_reg + 27'h1;
        end
    end

    // software registers, hardware updates of the input-off bit win
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || sw_rst) begin
            ctrl_reg <= CTRL_RST;
            fast_reg <= FAST_RST;
            pre_reg  <= PRE_RST;
            term_reg <= TERM_RST;
            comp_reg <= COMP_RST;
            misc_reg <= MISC_RST;
            vreg_reg <= VREG_RST;
        end else begin
            if (wr) begin
                unique case (paddr_i)
                    REG_CTRL: ctrl_reg <= pwdata_i[7:0] & CTRL_MSK;
                    REG_FAST: fast_reg <= pwdata_i[7:0] & FAST_MSK;
                    REG_PRE:  pre_reg  <= pwdata_i[7:0] & PRE_MSK;
                    REG_TERM: term_reg <= pwdata_i[7:0] & TERM_MSK;
                    REG_COMP: comp_reg <= pwdata_i[7:0] & COMP_MSK;
                    REG_MISC: misc_reg <= pwdata_i[7:0] & MISC_MSK;
                    REG_VREG: vreg_reg <= pwdata_i[12:0];
                    default:  ;
                endcase
            end
            if (state_next == ST_FAULT && state_reg != ST_FAULT)
                ctrl_reg[CTRL_HIZ] <= !host_mode;
        end
    end

    // fault field: set on completion or expiry, cleared by a status read
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || sw_rst)
            fault_reg <= 2'b00;
        else if (int_ev)
            fault_reg <= FLT_CHG;
        else if (rd && paddr_i == REG_STAT)
            fault_reg <= 2'b00;
    end

    // interrupt pulse generator
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            int_reg <= 32'h0;
            int_n_o <= 1'b1;
        end else if (int_ev) begin
            int_reg <= 32'(INT_CYC - 1);
            int_n_o <= 1'b0;
        end else if (int_reg != 32'h0) begin
            int_reg <= int_reg - 32'h1;
        end else begin
            int_n_o <= 1'b1;
        end
    end

    // current and voltage targets
    always_comb begin
        ir_mv    = 20'(drive_o.ichg_ma) * 20'(comp_reg[7:5]) * R_STEP_MOHM / MOHM_PER_OHM;
        clamp_mv = 20'(comp_reg[4:2]) * CLAMP_STEP_MV;
        if (state_reg == ST_PRE)
            ichg_next = sense_i.vbat_below_2v ? I_SHORT_MA
                        : PRE_BASE_MA + 13'(pre_reg[7:4]) * PRE_STEP_MA;
        else if (state_reg != ST_FAST)
            ichg_next = 13'h0;
        else if ((sense_i.ts_cool && term_reg[TERM_COOL]) || fast_reg[FAST_RED])
            ichg_next = fast_ma(fast_reg[7:2]) / 13'h5;
        else
            ichg_next = fast_ma(fast_reg[7:2]);
        if (sense_i.ts_warm)
            vreg_next = misc_reg[MISC_WARM] ? V_WARM_HI_MV : V_WARM_LO_MV;
        else
            vreg_next = vreg_reg + 13'(ir_mv < clamp_mv ? ir_mv : clamp_mv);
    end

    // registered outputs toward the power stage and pins
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            drive_o      <= '0;
            phase_o      <= PH_OFF;
            bat_switch_o <= 1'b0;
            stat_oe_o    <= 1'b0;
            hiz_o        <= 1'b0;
        end else begin
            drive_o.ichg_ma <= ichg_next;
            drive_o.vreg_mv <= vreg_next;
            hiz_o           <= input_off_state;
            bat_switch_o    <= charging | supplement_req_i;
            unique case (state_reg)
                ST_PRE:  phase_o <= PH_PRE;
                ST_FAST: phase_o <= PH_FAST;
                ST_SUSP: phase_o <= sense_i.vbat_below_3v ? PH_PRE : PH_FAST;
                ST_DONE: phase_o <= PH_DONE;
                default: phase_o <= PH_OFF;
            endcase
            if (state_reg == ST_SUSP || state_reg == ST_FAULT)
                stat_oe_o <= blink_reg;
            else if (state_reg == ST_FAST && term_reg[TERM_EARLY] && sense_i.ichg_below_800)
                stat_oe_o <= 1'b0;
            else
                stat_oe_o <= charging;
        end
    end

    // apb slave: one wait cycle, registered read data
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
            if (psel_i && penable_i && !pready_o && !pwrite_i) begin
                unique case (paddr_i)
                    REG_CTRL: prdata_o <= {24'h0, ctrl_reg};
                    REG_FAST: prdata_o <= {24'h0, fast_reg};
                    REG_PRE:  prdata_o <= {24'h0, pre_reg};
                    REG_TERM: prdata_o <= {24'h0, term_reg};
                    REG_COMP: prdata_o <= {24'h0, comp_reg};
                    REG_MISC: prdata_o <= {24'h0, misc_reg};
                    REG_STAT: prdata_o <= {26'h0, input_off_state, regulate, fault_reg, phase_o};
                    REG_VREG: prdata_o <= {19'h0, vreg_reg};
                    default:  prdata_o <= 32'h0;
                endcase
            end
        end
    end

    // checks
    int_pulse_low_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $fell(int_n_o) |=> !int_n_o [*8]) else $error("interrupt pulse too short");
    done_fault_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (state_reg != ST_DONE && state_next == ST_DONE && !sw_rst) |=> fault_reg == FLT_CHG && !int_n_o)
        else $error("termination did not flag the host");
    no_term_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (state_reg == ST_FAST && !term_reg[TERM_EN] && charge_ok) |=> state_reg != ST_DONE)
        else $error("terminated while termination disabled");
    timer_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!tmr_en && !start_cycle && !ext_rst) |=> $stable(timer_reg)) else $error("timer ran while disabled");
    short_current_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (state_reg == ST_PRE && sense_i.vbat_below_2v) |=> drive_o.ichg_ma == I_SHORT_MA)
        else $error("battery short current wrong");
    warm_volt_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sense_i.ts_warm |=> drive_o.vreg_mv == ($past(misc_reg[MISC_WARM]) ? V_WARM_HI_MV : V_WARM_LO_MV))
        else $error("warm zone voltage wrong");
    window_start_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (state_reg == ST_IDLE && !sense_i.ts_in_window) |=> state_reg == ST_IDLE)
        else $error("cycle started outside thermistor window");
    expiry_hiz_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (charging && charge_ok && tmr_exp && !host_mode && !sw_rst) |=> input_off_state ##1 hiz_o)
        else $error("default mode expiry did not set input off");
    early_done_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (state_reg == ST_FAST && term_reg[TERM_EARLY] && sense_i.ichg_below_800) |=> !stat_oe_o)
        else $error("early done not shown on status pin");
endmodule

// >>> verif/ccc_batt_model.sv
// Purpose: cell, thermistor and loop flags seen by the charge logic
// Assumes: bench sets cell voltage, current and temperature state
// Notes:   thresholds are plain defaults
`timescale 1ns/1ps
module ccc_batt_model #(
    parameter logic [12:0] RECHG_MV = 13'h1004,
    parameter logic [12:0] LOW_MV   = 13'h0bb8,
    parameter logic [12:0] TERM_MA  = 13'h0100
) (
    // cell state from bench
    input  wire logic [12:0]    vbat_mv_i,
    input  wire logic [12:0]    ibat_ma_i,
    input  wire logic           ts_ok_i,
    input  wire logic           loop_i,
    input  wire logic [1:0]     zone_i,      // {cool, warm} thermistor zone
    // comparator flags
    output ccc_pkg::ccc_sense_t sense_o
);
    import ccc_pkg::*;
    // comparators settle at once, no hysteresis
    always_comb begin
        sense_o = '0;
        sense_o.vbat_below_2v    = vbat_mv_i < 13'h07d0;
        sense_o.vbat_below_3v    = vbat_mv_i < 13'h0bb8;
        sense_o.vbat_below_low   = vbat_mv_i < LOW_MV;
        sense_o.vbat_above_rechg = vbat_mv_i > RECHG_MV;
        sense_o.ichg_below_term  = ibat_ma_i < TERM_MA;
        sense_o.ichg_below_800   = ibat_ma_i < 13'h0320;
        sense_o.ts_in_window     = ts_ok_i;
        sense_o.input_power_limit_loop = loop_i;
        sense_o.ts_cool          = zone_i[1];
        sense_o.ts_warm          = zone_i[0];
    end
endmodule

// >>> verif/charge_cycle_control_bench.sv
// Purpose: self-checking bench of the charge-cycle block
// Assumes: short tick and interrupt counts
// Notes:   apb master waits for pready
`timescale 1ns/1ps
module charge_cycle_control_bench;
    import ccc_pkg::*;
    logic clk, rstn, psel, pen, pwr, ce_n, ts, lp, rdy, err, sw, soe, irq_n, hz, sup;
    logic [1:0] zn;
    logic [7:0] pa;
    logic [31:0] pwd, prd, q;
    logic [12:0] vb, ib;
    logic [1:0] ph;
    ccc_sense_t sn;
    ccc_drive_t dr;
    int fails, checks_done, n;
    // address, expected read data, expected error
    logic [40:0] rows [6] = '{{8'h04, 32'h60, 1'b0}, {8'h08, 32'h10, 1'b0}, {8'h0c, 32'h8a, 1'b0},
        {8'h14, 32'h40, 1'b0}, {8'h10, 32'h0, 1'b0}, {8'h20, 32'h0, 1'b1}};
    ccc_top #(.TICK_CYC(10), .INT_CYC(16)) u_dut (.core_clk_i(clk), .resetn_i(rstn), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
        .pslverr_o(err), .sense_i(sn), .ce_n_i(ce_n), .supplement_req_i(sup), .drive_o(dr),
        .phase_o(ph), .bat_switch_o(sw), .stat_oe_o(soe), .int_n_o(irq_n), .hiz_o(hz));
    ccc_batt_model u_bat (.vbat_mv_i(vb), .ibat_ma_i(ib), .ts_ok_i(ts), .loop_i(lp), .zone_i(zn),
        .sense_o(sn));
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // one apb transfer, entered just after an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk) pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = prd;
        e = err;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask
    task test_done;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // clock
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // watchdog
    initial begin
        #200us fails++;
        test_done();
    end
    // main sequence
    initial begin
        logic e;
        {rstn, psel, pen, pwr, pa, pwd, lp, ts, sup, zn} = '0;
        ce_n = 1;
        vb = 13'h09c4;
        ib = 13'h0400;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(irq_n, 1, "int idle");
        chk(ph, 2'b00, "phase after reset");
        foreach (rows[i]) begin
            apb(0, rows[i][40:33], 0, e);
            chk(q, rows[i][32:1], "reset read");
            chk(e, rows[i][0], "reset read error");
        end
        ce_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk(ph, 2'b00, "start outside window");
        ts <= 1'b1;
        repeat (4) @(posedge clk);
        chk({ph, dr.ichg_ma}, {2'b01, 13'h0100}, "precharge");
        vb <= 13'h0e74;
        repeat (4) @(posedge clk);
        chk({ph, dr.ichg_ma}, {2'b10, 13'h0800}, "fast");
        chk({soe, dr.vreg_mv}, {1'b1, 13'h1070}, "charging status and plain target");
        apb(1, 8'h10, 32'hfc, e);
        repeat (2) @(posedge clk);
        chk(dr.vreg_mv, 13'h10e0, "clamp limits compensation");
        apb(1, 8'h10, 32'h3c, e);
        repeat (2) @(posedge clk);
        chk(dr.vreg_mv, 13'h1084, "ir drop compensation");
        zn <= 2'b01;
        repeat (2) @(posedge clk);
        chk(dr.vreg_mv, 13'h0fd2, "warm low voltage");
        apb(1, 8'h14, 32'h50, e);
        repeat (2) @(posedge clk);
        chk(dr.vreg_mv, 13'h1068, "warm high voltage");
        zn <= 2'b10;
        apb(1, 8'h0c, 32'h4b, e);
        repeat (2) @(posedge clk);
        chk(dr.ichg_ma, 13'h0199, "cool current cut");
        zn <= 2'b00;
        apb(1, 8'h04, 32'h61, e);
        repeat (2) @(posedge clk);
        chk(dr.ichg_ma, 13'h0199, "reduced current");
        apb(1, 8'h04, 32'h60, e);
        vb <= 13'h109a;
        ib <= 13'h0064;
        repeat (6) @(posedge clk);
        chk(ph, 2'b10, "term disabled");
        chk(soe, 1'b0, "early done on status pin");
        lp <= 1'b1;
        apb(1, 8'h0c, 32'h8a, e);
        repeat (6) @(posedge clk);
        chk(ph, 2'b10, "term during regulation");
        lp <= 1'b0;
        n = 0;
        while (irq_n !== 1'b0 && n < 20) @(posedge clk) n++;
        n = 0;
        while (irq_n === 1'b0 && n < 40) @(posedge clk) n++;
        chk(n, 16, "int pulse length");
        chk({ph, sw, hz}, {2'b11, 1'b0, 1'b0}, "done, switch off");
        sup <= 1'b1;
        repeat (2) @(posedge clk);
        chk(sw, 1'b1, "supplement after done");
        sup <= 1'b0;
        apb(0, 8'h18, 0, e);
        chk(q[3:2], 2'b11, "fault field");
        test_done();
    end
endmodule
